// *** design/pcg_params.svh ***
// Offsets, field positions, reset values and masks of the peripheral clock gating block.
`ifndef PCG_PARAMS_SVH
`define PCG_PARAMS_SVH
`define PCG_ADDR_W 4
`define PCG_OFF_GATE0 4'h0
`define PCG_OFF_GATE1 4'h1
`define PCG_OFF_GATE2 4'h2
`define PCG_OFF_GATE3 4'h3
`define PCG_GATE_RST 8'h00
`define PCG_NUM_MOD 32
`define PCG_IDX_CAL 13
`define PCG_MASK_FULL 32'hFFFF_FFFF
`define PCG_MASK_SMALL 32'h3E5F_DFFF
`endif

// *** design/pcg_pkg.sv ***
// Types shared by the peripheral clock gating block.
package pcg_pkg;
    // Software register request: one strobe per cycle.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } pcg_bus_req_t;
    // Peripheral register access request, steered to one module by index.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] mod;
        logic [7:0] wdata;
    } pcg_acc_req_t;
    // State of the calendar clock bit unlock.
    typedef enum logic {
        pcg_st_locked,
        pcg_st_armed
    } pcg_unlock_t;
endpackage

// *** design/pcg_gating.sv ***
// Peripheral clock gating: four gating registers, per-module clock enables and access gating.
//
// Summary of operation
// R1: A cleared function enable stops a module but leaves its registers accessible.
// R2: A gating bit written to one stops all clocks of that module.
// R3: Writes to a gated module are dropped and its reads are not valid; the code still raises o_acc_rvalid for them, with data zero.
// R4: Four 8-bit read/write gating registers, all zero after reset, every module clocked.
// R5: Register 3: bit7 capture 10, bit6 capture 9, bits5..1 capture 8..4, bit0 timer 12.
// R6: Register 2: bits7..3 timers 10,8,7,6,5; bits2..0 comparators 3,2,1.
// R7: Register 1: parallel port, charge-time, calendar, timers 4..1, external memory bus.
// R8: Register 0: enhanced capture 3..1, serial 2,1, sync serial 2,1, converter.
// R9: Calendar gating bit accepts a one only right after the write unlock.
// R10: Small-memory variant: capture 10,9, timers 12,10,7, calendar bits read zero.
// R11: Clearing a gating bit restores the module's clocks.
// R12: Gated module reads return zero and its write strobes are suppressed.
`timescale 1ns/10ps
`include "pcg_params.svh"

module pcg_gating #(
    parameter bit SMALL_MEM = 1'b0
) (
    input wire logic i_ref_clk,                  // System clock, 100 MHz.
    input wire logic i_rstn,                     // Synchronous reset, active low.
    input pcg_pkg::pcg_bus_req_t i_bus,          // Software register request.
    output logic [7:0] o_rdata,                  // Register read data, cycle after read.
    input wire logic i_unlock,                   // Pulse: write unlock sequence completed.
    input wire logic [31:0] i_func_en,           // Function enable bit of each module.
    output logic [31:0] o_clk_en,                // Clock enable of each module.
    output logic [31:0] o_func_run,              // Module clocked and functionally enabled.
    input pcg_pkg::pcg_acc_req_t i_acc,          // Peripheral register access request.
    output logic [31:0] o_acc_wr_stb,            // Write strobe toward each module.
    output logic [31:0] o_acc_rd_stb,            // Read strobe toward each module.
    output logic [7:0] o_acc_wdata,              // Write data toward the modules.
    input wire logic [7:0] i_acc_rdata,          // Read data from the strobed module.
    output logic [7:0] o_acc_rdata,              // Read data back to software.
    output logic o_acc_rvalid                    // Read answer marker.
);

    localparam logic [31:0] IMPL_MASK = SMALL_MEM ? `PCG_MASK_SMALL : `PCG_MASK_FULL;
    localparam logic [3:0] OFFS [4] = '{`PCG_OFF_GATE0, `PCG_OFF_GATE1,
                                        `PCG_OFF_GATE2, `PCG_OFF_GATE3};

    logic [31:0] gate_q;
    logic [31:0] gate_d;
    logic [31:0] clk_en_q;
    logic [31:0] func_run_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [31:0] wr_stb_q;
    logic [31:0] wr_stb_d;
    logic [31:0] rd_stb_q;
    logic [31:0] rd_stb_d;
    logic [7:0] acc_wdata_q;
    logic rd_pend_q;
    logic rd_ok_q;
    logic [7:0] acc_rdata_q;
    logic acc_rvalid_q;
    pcg_pkg::pcg_unlock_t unlock_q;
    pcg_pkg::pcg_unlock_t unlock_d;

    // Register address decode.
    wire [3:0] reg_hit;
    wire [3:0] reg_wr;
    wire any_hit;
    wire armed;
    wire acc_gated;

    genvar r;
    generate
        for (r = 0; r < 4; r = r + 1) begin : g_dec
            assign reg_hit[r] = (i_bus.addr == OFFS[r]);
            assign reg_wr[r] = i_bus.wr && reg_hit[r];
        end
    endgenerate
    assign any_hit = |reg_hit;
    assign armed = (unlock_q == pcg_pkg::pcg_st_armed);

    // Read selection; an unmapped address answers zero.
    assign rdata_d = !i_bus.rd ? 8'h00 :
                     reg_hit[0] ? gate_q[7:0] :
                     reg_hit[1] ? gate_q[15:8] :
                     reg_hit[2] ? gate_q[23:16] :
                     reg_hit[3] ? gate_q[31:24] : 8'h00;

    // Per-module gating bit, register-field mapping and access gating.
    genvar i;
    generate
        for (i = 0; i < `PCG_NUM_MOD; i = i + 1) begin : g_mod
            localparam bit IS_CAL = (i == `PCG_IDX_CAL);
            wire wbit = i_bus.wdata[i % 8];                  // [R5] [R6] [R7] [R8]
            wire set_ok = IS_CAL ? (armed || gate_q[i]) : 1'b1;  // [R9]
            wire hit = (i_acc.mod == 5'(i));
            // Unimplemented bits never hold a one and so read as zero.
            assign gate_d[i] = IMPL_MASK[i] &&
                (reg_wr[i / 8] ? (wbit && set_ok) : gate_q[i]);  // [R4] [R10] [R11]
            // Register access depends on the gating bit only, not on the function enable.
            assign wr_stb_d[i] = i_acc.wr && hit && !gate_q[i];  // [R1] [R3] [R12]
            assign rd_stb_d[i] = i_acc.rd && hit && !gate_q[i];  // [R1] [R3]
        end
    endgenerate
    assign acc_gated = gate_q[i_acc.mod];

    // Unlock arms on the unlock pulse and is consumed by the next register write.
    assign unlock_d = i_unlock ? pcg_pkg::pcg_st_armed :
                      i_bus.wr ? pcg_pkg::pcg_st_locked : unlock_q;  // [R9]

    // Gating registers, clock enables and unlock state.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            gate_q <= {4{`PCG_GATE_RST}};                   // [R4]
            clk_en_q <= 32'hFFFF_FFFF;                       // [R4]
            func_run_q <= 32'h0000_0000;
            unlock_q <= pcg_pkg::pcg_st_locked;
        end else begin
            gate_q <= gate_d;
            clk_en_q <= ~gate_d;                             // [R2] [R11]
            func_run_q <= ~gate_d & i_func_en;               // [R1]
            unlock_q <= unlock_d;
        end
    end

    // Software read answer.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Access strobes toward the modules, gated by their bits.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            wr_stb_q <= 32'h0000_0000;
            rd_stb_q <= 32'h0000_0000;
            acc_wdata_q <= 8'h00;
            rd_pend_q <= 1'b0;
            rd_ok_q <= 1'b0;
        end else begin
            wr_stb_q <= wr_stb_d;                            // [R3]
            rd_stb_q <= rd_stb_d;
            acc_wdata_q <= i_acc.wdata;
            rd_pend_q <= i_acc.rd;
            rd_ok_q <= i_acc.rd && !acc_gated;
        end
    end

    // Read data return; a gated module answers zero.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            acc_rdata_q <= 8'h00;
            acc_rvalid_q <= 1'b0;
        end else begin
            acc_rdata_q <= rd_ok_q ? i_acc_rdata : 8'h00;    // [R12]
            acc_rvalid_q <= rd_pend_q;
        end
    end

    // Outputs come straight from flip-flops.
    assign o_rdata = rdata_q;
    assign o_clk_en = clk_en_q;
    assign o_func_run = func_run_q;
    assign o_acc_wr_stb = wr_stb_q;
    assign o_acc_rd_stb = rd_stb_q;
    assign o_acc_wdata = acc_wdata_q;
    assign o_acc_rdata = acc_rdata_q;
    assign o_acc_rvalid = acc_rvalid_q;

    // Checks of the gating behaviour.
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rstn);

    property p_reset_clear;
        !$past(i_rstn) |-> (gate_q == 32'h0000_0000) && (o_clk_en == 32'hFFFF_FFFF);
    endproperty
    a_reset_clear: assert property (p_reset_clear) // [R4]
        else $error("Gating state not cleared by reset.");

    property p_clk_follow;
        (gate_q != $past(gate_q)) |-> (o_clk_en == ~gate_q);
    endproperty
    a_clk_follow: assert property (p_clk_follow) // [R2]
        else $error("Clock enable does not follow the gating bits.");

    // A back-to-back write may gate the byte again, so only a quiet next cycle is checked.
    property p_clk_restore;
        reg_wr[1] && (i_bus.wdata == 8'h00) ##1 !reg_wr[1]
            |-> (o_clk_en[15:8] == 8'hFF) [*2];
    endproperty
    a_clk_restore: assert property (p_clk_restore) // [R11]
        else $error("Clearing a gating bit did not restore the clocks.");

    property p_unimpl_zero;
        (gate_q & ~IMPL_MASK) == 32'h0000_0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) // [R10]
        else $error("Unimplemented gating bit is set.");

    property p_map_reg3;
        reg_wr[3] |=> gate_q[31:24] == ($past(i_bus.wdata) & IMPL_MASK[31:24]);
    endproperty
    a_map_reg3: assert property (p_map_reg3) // [R5]
        else $error("Register 3 write not mapped to its modules.");

    property p_map_reg2;
        reg_wr[2] |=> gate_q[23:16] == ($past(i_bus.wdata) & IMPL_MASK[23:16]);
    endproperty
    a_map_reg2: assert property (p_map_reg2) // [R6]
        else $error("Register 2 write not mapped to its modules.");

    property p_map_reg1;
        reg_wr[1] |=> (gate_q[12:8] == $past(i_bus.wdata[4:0]))
            && (gate_q[15:14] == $past(i_bus.wdata[7:6]));
    endproperty
    a_map_reg1: assert property (p_map_reg1) // [R7]
        else $error("Register 1 write not mapped to its modules.");

    property p_map_reg0;
        reg_wr[0] |=> (gate_q[7:0] == $past(i_bus.wdata))
            && (o_clk_en[7:0] == ~$past(i_bus.wdata));
    endproperty
    a_map_reg0: assert property (p_map_reg0) // [R8]
        else $error("Register 0 write not mapped to its modules.");

    property p_readback;
        i_bus.rd && reg_hit[1] |=> o_rdata == $past(gate_q[15:8]) ##1 o_rdata == 8'h00
            || $past(i_bus.rd);
    endproperty
    a_readback: assert property (p_readback) // [R4]
        else $error("Register read does not return the gating bits.");

    property p_cal_locked;
        reg_wr[1] && !armed && !gate_q[`PCG_IDX_CAL] |=> !gate_q[`PCG_IDX_CAL];
    endproperty
    a_cal_locked: assert property (p_cal_locked) // [R9]
        else $error("Calendar gating bit set without unlock.");

    property p_wr_blocked;
        i_acc.wr && acc_gated |=> o_acc_wr_stb == 32'h0000_0000;
    endproperty
    a_wr_blocked: assert property (p_wr_blocked) // [R3]
        else $error("Write strobe reached a gated module.");

    property p_rd_zero;
        i_acc.rd && acc_gated |-> ##2 o_acc_rvalid && (o_acc_rdata == 8'h00);
    endproperty
    a_rd_zero: assert property (p_rd_zero) // [R12]
        else $error("Gated module read did not return zero.");

    property p_rd_open;
        i_acc.rd && !acc_gated |=> $onehot(o_acc_rd_stb) ##1 o_acc_rvalid;
    endproperty
    a_rd_open: assert property (p_rd_open) // [R1]
        else $error("Ungated module read was not strobed and answered.");

    property p_func_run;
        ##1 (o_func_run & gate_q) == 32'h0000_0000;
    endproperty
    a_func_run: assert property (p_func_run) // [R1]
        else $error("Gated module reported as running.");

    // An open module gets exactly one write strobe and the data of its request.
    property p_wr_open;
        i_acc.wr && !acc_gated |=> $onehot(o_acc_wr_stb) && (o_acc_wdata == $past(i_acc.wdata));
    endproperty
    a_wr_open: assert property (p_wr_open) // [R1]
        else $error("Ungated module write was not strobed.");

    property p_rd_blocked;
        i_acc.rd && acc_gated |=> o_acc_rd_stb == 32'h0000_0000;
    endproperty
    a_rd_blocked: assert property (p_rd_blocked) // [R3]
        else $error("Read strobe reached a gated module.");

    // Read data stands for one cycle only.
    property p_rdata_idle;
        !i_bus.rd |=> o_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) // [R4]
        else $error("Read data present without a read.");

    property p_unmapped_wr;
        i_bus.wr && !any_hit |=> gate_q == $past(gate_q);
    endproperty
    a_unmapped_wr: assert property (p_unmapped_wr) // [R4]
        else $error("Write to an unmapped address changed the gating bits.");

    // A register write uses up the unlock, unless an unlock pulse comes in the same cycle.
    property p_unlock_used;
        armed && i_bus.wr && !i_unlock |=> !armed;
    endproperty
    a_unlock_used: assert property (p_unlock_used) // [R9]
        else $error("Unlock not consumed by a register write.");

    property p_cal_armed;
        reg_wr[1] && armed && i_bus.wdata[5] |=> gate_q[`PCG_IDX_CAL] == IMPL_MASK[`PCG_IDX_CAL];
    endproperty
    a_cal_armed: assert property (p_cal_armed) // [R9]
        else $error("Calendar gating bit not set after unlock.");

    c_gated_write: cover property (i_acc.wr && acc_gated);
    c_cal_set: cover property (armed && reg_wr[1] && i_bus.wdata[5] ##1 gate_q[`PCG_IDX_CAL]);
    c_gated_read: cover property (i_acc.rd && acc_gated ##2 o_acc_rvalid);
    c_restore: cover property (gate_q[0] ##1 !gate_q[0]);
    c_unmapped_write: cover property (i_bus.wr && !any_hit);

endmodule

// *** test/pcg_periph_model.sv ***
// Behavioural model of the peripherals behind the gating block.
`timescale 1ns/10ps
module pcg_periph_model (
    input wire logic i_ref_clk,       // System clock.
    input wire logic [31:0] i_wr_stb, // Write strobe per module.
    input wire logic [31:0] i_rd_stb, // Read strobe per module.
    input wire logic [7:0] i_wdata,   // Write data.
    output logic [7:0] o_rdata        // Read data, valid only while a read strobe is high.
);
    logic [7:0] mem_q [32] = '{default: 8'h00};
    logic [7:0] idle_q = 8'h00;
    logic [7:0] sel;
    // Each module keeps one register; idle data keeps changing so a stale value never matches.
    always @(posedge i_ref_clk) begin
        idle_q <= idle_q + 8'h3B;
        for (int k = 0; k < 32; k++) begin
            if (i_wr_stb[k]) begin
                mem_q[k] <= i_wdata;
            end
        end
    end
    // Read mux over the strobed module.
    always_comb begin
        sel = idle_q;
        for (int k = 0; k < 32; k++) begin
            if (i_rd_stb[k]) begin
                sel = mem_q[k];
            end
        end
    end
    assign o_rdata = sel;
endmodule

// *** test/testbench.sv ***
// Self-checking bench of the peripheral clock gating block.
`timescale 1ns/10ps
`include "pcg_params.svh"
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic unlock = 1'b0;
    logic [31:0] func_en = 32'h0;
    pcg_pkg::pcg_bus_req_t bus = '0;
    pcg_pkg::pcg_acc_req_t acc = '0;
    logic [7:0] rdata, acc_wdata, acc_rdata, per_rdata;
    logic [31:0] clk_en, clk_en_s, func_run, wr_stb, rd_stb, gate_exp, op;
    logic rvalid;
    logic armed;
    logic [7:0] shadow [32] = '{default: 8'h00};
    integer seed = 32'h35C5;
    integer fails = 0;
    integer num_checks = 0;
    integer i;
    // Full variant under test, small variant watched for its clock enables only.
    pcg_gating i_pcg_gating (.i_ref_clk(clk), .i_rstn(rstn), .i_bus(bus), .o_rdata(rdata),
        .i_unlock(unlock), .i_func_en(func_en), .o_clk_en(clk_en), .o_func_run(func_run),
        .i_acc(acc), .o_acc_wr_stb(wr_stb), .o_acc_rd_stb(rd_stb), .o_acc_wdata(acc_wdata),
        .i_acc_rdata(per_rdata), .o_acc_rdata(acc_rdata), .o_acc_rvalid(rvalid));
    pcg_gating #(.SMALL_MEM(1'b1)) i_pcg_gating_small (.i_ref_clk(clk), .i_rstn(rstn),
        .i_bus(bus), .o_rdata(), .i_unlock(unlock), .i_func_en(func_en), .o_clk_en(clk_en_s),
        .o_func_run(), .i_acc(acc), .o_acc_wr_stb(), .o_acc_rd_stb(), .o_acc_wdata(),
        .i_acc_rdata(per_rdata), .o_acc_rdata(), .o_acc_rvalid());
    pcg_periph_model i_pcg_periph_model (.i_ref_clk(clk), .i_wr_stb(wr_stb),
        .i_rd_stb(rd_stb), .i_wdata(acc_wdata), .o_rdata(per_rdata));
    // Free-running system clock.
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Expected register read data from the modelled gating bits.
    function automatic logic [7:0] exp_reg(input logic [3:0] a, input logic [31:0] g);
        return (a < 4'h4) ? g[a*8 +: 8] : 8'h00;
    endfunction
    // Expected clock enables: implemented gating bits stop their module.
    function automatic logic [31:0] exp_clk(input logic [31:0] g, input logic [31:0] mask);
        return ~(g & mask);
    endfunction
    task automatic end_of_test;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic arm;
        @(posedge clk) unlock <= 1'b1;
        @(posedge clk) unlock <= 1'b0;
        armed = 1'b1;
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        logic lock_cal;
        lock_cal = !armed && !gate_exp[13];
        @(posedge clk) bus <= {1'b1, 1'b0, a, d};
        @(posedge clk) bus <= '0;
        if (a < 4'h4) gate_exp[a*8 +: 8] = d;
        if (a == 4'h1 && lock_cal) gate_exp[13] = 1'b0;
        armed = 1'b0;
        #1;
        chk(clk_en, exp_clk(gate_exp, `PCG_MASK_FULL));
        chk(clk_en_s, exp_clk(gate_exp, `PCG_MASK_SMALL));
    endtask
    task automatic bus_rd(input logic [3:0] a);
        @(posedge clk) bus <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clk) bus <= '0;
        #1;
        chk(rdata, exp_reg(a, gate_exp));
    endtask
    task automatic acc_op(input logic w, input logic [4:0] m, input logic [7:0] d);
        logic g;
        g = gate_exp[m];
        @(posedge clk) acc <= {w, ~w, m, d};
        @(posedge clk) acc <= '0;
        #1;
        chk(w ? wr_stb : rd_stb, g ? 32'h0 : 32'h1 << m);
        if (w) begin
            chk(acc_wdata, d);
            if (!g) shadow[m] = d;
        end else begin
            @(posedge clk);
            #1;
            chk({rvalid, acc_rdata}, {1'b1, g ? 8'h00 : shadow[m]});
        end
    endtask
    // Hang guard.
    initial begin
        #100000;
        fails++;
        end_of_test();
    end
    // Main sequence: reset values, calendar unlock, then random traffic.
    initial begin
        gate_exp = 32'h0;
        armed = 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk(clk_en, 32'hFFFF_FFFF);
        for (i = 0; i < 5; i++) bus_rd(i[3:0]);
        $display("reset test done");
        bus_wr(4'h1, 8'hFF);
        bus_wr(4'h1, 8'h00);
        arm();
        bus_wr(4'h1, 8'h20);
        bus_rd(4'h1);
        acc_op(1'b1, 5'd13, 8'h5A);
        acc_op(1'b0, 5'd13, 8'h00);
        bus_wr(4'h1, 8'h00);
        acc_op(1'b1, 5'd13, 8'hA5);
        acc_op(1'b0, 5'd13, 8'h00);
        $display("unlock test done");
        for (i = 0; i < 80; i++) begin
            op = $random(seed);
            case (op[1:0])
                2'd0: begin
                    if (op[2]) arm();
                    bus_wr((op[5] & op[6]) ? 4'h9 : {2'b00, op[4:3]}, op[15:8]);
                end
                2'd1: bus_rd((op[5] & op[6]) ? 4'hC : {2'b00, op[4:3]});
                2'd2: acc_op(op[7], op[12:8], op[23:16]);
                default: begin
                    @(posedge clk) func_en <= $random(seed);
                    @(posedge clk);
                    #1;
                    chk(func_run, ~gate_exp & func_en);
                end
            endcase
        end
        $display("random test done");
        end_of_test();
    end
endmodule
